// ==== inc/mcf_params.svh ====
// constants of the mac control and filter register set
`ifndef MCF_PARAMS_SVH
`define MCF_PARAMS_SVH

// register indices on the synchronizer port
`define MCF_IDX_FIRST 8'h01
`define MCF_IDX_LAST 8'h0c
`define MCF_IDX_MAC_CONTROL 8'h01
`define MCF_IDX_STATION_ADDRESS_HIGH 8'h02
`define MCF_IDX_STATION_ADDRESS_LOW 8'h03
`define MCF_IDX_GROUP_HASH_UPPER 8'h04
`define MCF_IDX_GROUP_HASH_LOWER 8'h05
`define MCF_IDX_PHY_MGMT_ACCESS 8'h06
`define MCF_IDX_PHY_MGMT_VALUE 8'h07
`define MCF_IDX_PAUSE_CONTROL 8'h08
`define MCF_IDX_TAG_MATCH_FIRST 8'h09
`define MCF_IDX_TAG_MATCH_SECOND 8'h0a
`define MCF_IDX_WAKE_PATTERN_FILTER 8'h0b
`define MCF_IDX_WAKE_CONTROL_STATUS 8'h0c
`define MCF_CSR_COUNT 12

// reset values, in index order
`define MCF_RST_MAC_CONTROL 32'h00040000
`define MCF_RST_STATION_ADDRESS_HIGH 32'h0000ffff
`define MCF_RST_STATION_ADDRESS_LOW 32'h0fffffff
`define MCF_RST_GROUP_HASH_UPPER 32'h00000000
`define MCF_RST_GROUP_HASH_LOWER 32'h00000000
`define MCF_RST_PHY_MGMT_ACCESS 32'h00000000
`define MCF_RST_PHY_MGMT_VALUE 32'h00000000
`define MCF_RST_PAUSE_CONTROL 32'h00000000
`define MCF_RST_TAG_MATCH_FIRST 32'h00000000
`define MCF_RST_TAG_MATCH_SECOND 32'h00000000
`define MCF_RST_WAKE_PATTERN_FILTER 32'h00000000
`define MCF_RST_WAKE_CONTROL_STATUS 32'h00000000

// mac_control fields
`define MCF_BIT_RECEIVE_EVERYTHING 31
`define MCF_BIT_BLOCK_OWN_FRAMES 23
`define MCF_BIT_INTERNAL_TURNAROUND 21
`define MCF_BIT_FULL_DUPLEX_SEL 20
`define MCF_BIT_ACCEPT_ALL_GROUP 19
`define MCF_BIT_ACCEPT_ANY_ADDRESS 18
`define MCF_BIT_INVERT_MATCH 17
`define MCF_BIT_DELIVER_DAMAGED 16
`define MCF_BIT_HASH_ONLY_MATCH 15
`define MCF_MAC_CONTROL_MASK 32'h80bf8000

// serial rom value register
`define MCF_OFS_SERIAL_ROM_VALUE 8'hb4
`define MCF_ROM_VALUE_RST 8'h00

// group hash
`define MCF_CRC_INIT 32'hffffffff
`define MCF_CRC_POLY 32'h04c11db7

// loopback changeover, longest time rounded down
`define MCF_CLK_PERIOD_NS 8
`define MCF_LOOP_SETTLE_NS 10000
`define MCF_LOOP_SETTLE_CYC (`MCF_LOOP_SETTLE_NS / `MCF_CLK_PERIOD_NS)

`endif

// ==== inc/mcf_pkg.sv ====
// types of the mac control and filter register set
package mcf_pkg;

    typedef logic [31:0] mcf_word_t;

    typedef struct packed {
        logic receive_everything;
        logic block_own_frames;
        logic internal_turnaround;
        logic full_duplex_sel;
        logic accept_all_group;
        logic accept_any_address;
        logic invert_match;
        logic deliver_damaged;
        logic hash_only_match;
    } mcf_mode_s;

    typedef struct packed {
        logic write;
        logic [7:0] index;
        mcf_word_t value;
    } mcf_cmd_s;

    typedef struct packed {
        logic [47:0] dest_addr;
        logic damaged;
    } mcf_rx_s;

    typedef struct packed {
        logic deliver;
        logic addr_pass;
        logic blocked;
    } mcf_rx_res_s;

endpackage

// ==== rtl/mcf_addr_filter.sv ====
// destination address filter of the receive path
`timescale 1ns/10ps
`include "mcf_params.svh"

module mcf_addr_filter import mcf_pkg::*; (
    // configuration
    input wire mcf_mode_s mode_in,
    input wire logic [47:0] station_in,
    input wire logic [63:0] hash_in,
    // frame
    input wire logic [47:0] dest_in,
    // result
    output logic pass_out,
    output logic perfect_out,
    output logic hash_hit_out
);

    // first transmitted bit is bit 0 of the first byte
    function automatic logic [31:0] mcf_crc(input logic [47:0] d);
        logic [31:0] c;
        c = `MCF_CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            if (c[31] ^ d[i]) begin
                c = {c[30:0], 1'b0} ^ `MCF_CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        return c;
    endfunction

    logic [31:0] crc;
    logic group;

    always_comb begin
        crc = mcf_crc(dest_in);
        group = dest_in[0];
        perfect_out = (dest_in == station_in);
        hash_hit_out = hash_in[crc[31:26]];
        if (mode_in.accept_any_address) begin
            pass_out = 1'b1;
        end else if (mode_in.hash_only_match) begin
            pass_out = hash_hit_out;
        end else if (group) begin
            pass_out = mode_in.accept_all_group | hash_hit_out;
        end else begin
            // inversion only under perfect matching
            pass_out = perfect_out ^ mode_in.invert_match;
        end
    end

endmodule // mcf_addr_filter

// ==== rtl/mcf_csr.sv ====
// mac control and status registers with mode and filter decisions
`timescale 1ns/10ps
`include "mcf_params.svh"

module mcf_csr import mcf_pkg::*; #(
    parameter int LOOP_SETTLE_CYC = `MCF_LOOP_SETTLE_CYC
) (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    // indexed synchronizer port
    input wire logic CMD_VALID_IN,
    input wire mcf_cmd_s CMD_IN,
    output logic CMD_DONE_OUT,
    output mcf_word_t CMD_RDATA_OUT,
    // serial rom value register
    input wire logic ROM_WR_IN,
    input wire mcf_word_t ROM_WDATA_IN,
    input wire logic ROM_LOAD_IN,
    input wire logic [7:0] ROM_LOAD_DATA_IN,
    output mcf_word_t ROM_RDATA_OUT,
    // transmit side
    input wire logic TXEN_IN,
    output logic PHY_TXEN_OUT,
    // receive decisions
    input wire logic RX_VALID_IN,
    input wire mcf_rx_s RX_IN,
    output logic RX_DONE_OUT,
    output mcf_rx_res_s RX_RES_OUT,
    // mode levels
    output logic LOOPBACK_OUT,
    output logic LOOP_BUSY_OUT,
    output logic FULL_DUPLEX_OUT,
    output logic HEARTBEAT_EN_OUT,
    output logic RX_GATE_OUT
);

    localparam int CW = $clog2(LOOP_SETTLE_CYC + 1);
    localparam logic [`MCF_CSR_COUNT-1:0][31:0] CSR_RESET = {
        `MCF_RST_WAKE_CONTROL_STATUS,
        `MCF_RST_WAKE_PATTERN_FILTER,
        `MCF_RST_TAG_MATCH_SECOND,
        `MCF_RST_TAG_MATCH_FIRST,
        `MCF_RST_PAUSE_CONTROL,
        `MCF_RST_PHY_MGMT_VALUE,
        `MCF_RST_PHY_MGMT_ACCESS,
        `MCF_RST_GROUP_HASH_LOWER,
        `MCF_RST_GROUP_HASH_UPPER,
        `MCF_RST_STATION_ADDRESS_LOW,
        `MCF_RST_STATION_ADDRESS_HIGH,
        `MCF_RST_MAC_CONTROL
    };
    localparam logic [3:0] SLOT_CTRL = 4'(`MCF_IDX_MAC_CONTROL - `MCF_IDX_FIRST);
    localparam logic [3:0] SLOT_ADDR_HIGH = 4'(`MCF_IDX_STATION_ADDRESS_HIGH - `MCF_IDX_FIRST);
    localparam logic [3:0] SLOT_ADDR_LOW = 4'(`MCF_IDX_STATION_ADDRESS_LOW - `MCF_IDX_FIRST);
    localparam logic [3:0] SLOT_HASH_UP = 4'(`MCF_IDX_GROUP_HASH_UPPER - `MCF_IDX_FIRST);
    localparam logic [3:0] SLOT_HASH_LO = 4'(`MCF_IDX_GROUP_HASH_LOWER - `MCF_IDX_FIRST);

    // register file
    logic [`MCF_CSR_COUNT-1:0][31:0] csr_r, csr_nxt;
    mcf_word_t rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic idx_ok;
    logic [3:0] slot;
    mcf_word_t ctrl;
    mcf_mode_s mode;

    always_comb begin
        idx_ok = (CMD_IN.index >= `MCF_IDX_FIRST) && (CMD_IN.index <= `MCF_IDX_LAST);
        slot = 4'(CMD_IN.index - `MCF_IDX_FIRST);
        csr_nxt = csr_r;
        rdata_nxt = rdata_r;
        done_nxt = CMD_VALID_IN;
        if (CMD_VALID_IN) begin
            if (!idx_ok) begin
                rdata_nxt = 32'h00000000;
            end else if (CMD_IN.write) begin
                if (slot == SLOT_CTRL) begin
                    csr_nxt[slot] = CMD_IN.value & `MCF_MAC_CONTROL_MASK;
                end else begin
                    csr_nxt[slot] = CMD_IN.value;
                end
                rdata_nxt = 32'h00000000;
            end else begin
                rdata_nxt = csr_r[slot];
            end
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            csr_r <= CSR_RESET;
            rdata_r <= 32'h00000000;
            done_r <= 1'b0;
        end else begin
            csr_r <= csr_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    assign CMD_DONE_OUT = done_r;
    assign CMD_RDATA_OUT = rdata_r;
    assign ctrl = csr_r[SLOT_CTRL];

    always_comb begin
        mode.receive_everything = ctrl[`MCF_BIT_RECEIVE_EVERYTHING];
        mode.block_own_frames = ctrl[`MCF_BIT_BLOCK_OWN_FRAMES];
        mode.internal_turnaround = ctrl[`MCF_BIT_INTERNAL_TURNAROUND];
        mode.full_duplex_sel = ctrl[`MCF_BIT_FULL_DUPLEX_SEL];
        mode.accept_all_group = ctrl[`MCF_BIT_ACCEPT_ALL_GROUP];
        mode.accept_any_address = ctrl[`MCF_BIT_ACCEPT_ANY_ADDRESS];
        mode.invert_match = ctrl[`MCF_BIT_INVERT_MATCH];
        mode.deliver_damaged = ctrl[`MCF_BIT_DELIVER_DAMAGED];
        mode.hash_only_match = ctrl[`MCF_BIT_HASH_ONLY_MATCH];
    end

    // serial rom value: the rom controller's load wins over a host write
    logic [7:0] rom_r, rom_nxt;

    always_comb begin
        rom_nxt = rom_r;
        if (ROM_LOAD_IN) begin
            rom_nxt = ROM_LOAD_DATA_IN;
        end else if (ROM_WR_IN) begin
            rom_nxt = ROM_WDATA_IN[7:0];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rom_r <= `MCF_ROM_VALUE_RST;
        end else begin
            rom_r <= rom_nxt;
        end
    end

    assign ROM_RDATA_OUT = {24'h000000, rom_r};

    // loopback changeover; a toggle mid-count restarts the wait
    logic lb_active_r, lb_active_nxt;
    logic [CW-1:0] lb_cnt_r, lb_cnt_nxt;
    logic lb_req_q;

    always_comb begin
        lb_active_nxt = lb_active_r;
        lb_cnt_nxt = lb_cnt_r;
        if (mode.internal_turnaround == lb_active_r || mode.internal_turnaround != lb_req_q) begin
            lb_cnt_nxt = '0;
        end else if (lb_cnt_r == CW'(LOOP_SETTLE_CYC - 1)) begin
            lb_active_nxt = mode.internal_turnaround;
            lb_cnt_nxt = '0;
        end else begin
            lb_cnt_nxt = lb_cnt_r + CW'(1);
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lb_active_r <= 1'b0;
            lb_cnt_r <= '0;
            lb_req_q <= 1'b0;
        end else begin
            lb_active_r <= lb_active_nxt;
            lb_cnt_r <= lb_cnt_nxt;
            lb_req_q <= mode.internal_turnaround;
        end
    end

    assign LOOPBACK_OUT = lb_active_r;
    assign LOOP_BUSY_OUT = mode.internal_turnaround != lb_active_r;
    // turned-around frames never reach the PHY
    assign PHY_TXEN_OUT = TXEN_IN & ~lb_active_r;
    // half duplex still lets the MAC defer; here only the mode level is handed on
    assign FULL_DUPLEX_OUT = mode.full_duplex_sel;
    assign HEARTBEAT_EN_OUT = ~mode.full_duplex_sel;
    assign RX_GATE_OUT = ~(mode.block_own_frames & TXEN_IN);

    // receive decision
    logic addr_pass;
    logic perfect;
    logic hash_hit;
    logic [47:0] station;
    logic [63:0] hash_table;

    assign station = {csr_r[SLOT_ADDR_HIGH][15:0], csr_r[SLOT_ADDR_LOW]};
    assign hash_table = {csr_r[SLOT_HASH_UP], csr_r[SLOT_HASH_LO]};

    mcf_addr_filter u_filter (
        .mode_in(mode),
        .station_in(station),
        .hash_in(hash_table),
        .dest_in(RX_IN.dest_addr),
        .pass_out(addr_pass),
        .perfect_out(perfect),
        .hash_hit_out(hash_hit)
    );

    mcf_rx_res_s res_r, res_nxt;
    logic rx_done_r, rx_done_nxt;

    always_comb begin
        res_nxt = res_r;
        rx_done_nxt = RX_VALID_IN;
        if (RX_VALID_IN) begin
            res_nxt.blocked = mode.block_own_frames & TXEN_IN;
            res_nxt.addr_pass = addr_pass;
            res_nxt.deliver = ~res_nxt.blocked
                & (addr_pass | mode.receive_everything)
                & (~RX_IN.damaged | mode.deliver_damaged);
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            res_r <= '0;
            rx_done_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            rx_done_r <= rx_done_nxt;
        end
    end

    assign RX_DONE_OUT = rx_done_r;
    assign RX_RES_OUT = res_r;

    // checks
    // changeover watch: counts busy cycles of a steady request, restarts on a toggle;
    // a counter because the full settle time is far too long for a delay range
    logic chk_prev_r, chk_prev_nxt;
    logic [CW:0] chk_wait_r, chk_wait_nxt;

    always_comb begin
        chk_prev_nxt = mode.internal_turnaround;
        chk_wait_nxt = '0;
        if (LOOP_BUSY_OUT && mode.internal_turnaround == chk_prev_r) begin
            chk_wait_nxt = chk_wait_r + (CW+1)'(1);
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            chk_prev_r <= 1'b0;
            chk_wait_r <= '0;
        end else begin
            chk_prev_r <= chk_prev_nxt;
            chk_wait_r <= chk_wait_nxt;
        end
    end

    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (RST_IN);

    a_loop_settle: assert property (
        chk_wait_r <= (CW+1)'(LOOP_SETTLE_CYC))
        else $error("loopback changeover took too long");

    a_reserved_zero: assert property (
        (ctrl & ~`MCF_MAC_CONTROL_MASK) == 32'h00000000)
        else $error("reserved control bit set");

    a_ctrl_write: assert property (
        CMD_VALID_IN && CMD_IN.write && CMD_IN.index == `MCF_IDX_MAC_CONTROL
        |=> ctrl == ($past(CMD_IN.value) & `MCF_MAC_CONTROL_MASK))
        else $error("control write not stored");

    a_read_back: assert property (
        CMD_VALID_IN && !CMD_IN.write && CMD_IN.index == `MCF_IDX_MAC_CONTROL
        |=> CMD_DONE_OUT && CMD_RDATA_OUT == $past(ctrl))
        else $error("control read wrong");

    a_any_address: assert property (
        RX_VALID_IN && mode.accept_any_address && !RX_IN.damaged && !TXEN_IN
        |=> RX_DONE_OUT && RX_RES_OUT.addr_pass && RX_RES_OUT.deliver)
        else $error("promiscuous frame refused");

    a_own_block: assert property (
        RX_VALID_IN && mode.block_own_frames && TXEN_IN
        |=> RX_RES_OUT.blocked && !RX_RES_OUT.deliver)
        else $error("own frame received");

    a_receive_all: assert property (
        RX_VALID_IN && mode.receive_everything && !RX_IN.damaged
        && !(mode.block_own_frames && TXEN_IN)
        |=> RX_RES_OUT.deliver && RX_RES_OUT.addr_pass == $past(addr_pass))
        else $error("receive all frame dropped");

    a_unicast_exact: assert property (
        RX_VALID_IN && !RX_IN.dest_addr[0] && RX_IN.dest_addr != station
        && !mode.accept_any_address && !mode.hash_only_match
        && !mode.invert_match && !mode.receive_everything
        |=> !RX_RES_OUT.deliver)
        else $error("unmatched unicast delivered");

    a_damaged_drop: assert property (
        RX_VALID_IN && RX_IN.damaged && !mode.deliver_damaged
        |=> !RX_RES_OUT.deliver)
        else $error("damaged frame delivered");

    a_loop_no_phy: assert property (
        lb_active_r && TXEN_IN |-> !PHY_TXEN_OUT)
        else $error("loopback frame sent to phy");

    a_heartbeat_off: assert property (
        ctrl[`MCF_BIT_FULL_DUPLEX_SEL] |-> !HEARTBEAT_EN_OUT && FULL_DUPLEX_OUT)
        else $error("heartbeat check in full duplex");

    a_rom_low_byte: assert property (
        ROM_WR_IN && !ROM_LOAD_IN |=> ROM_RDATA_OUT == {24'h000000, $past(ROM_WDATA_IN[7:0])})
        else $error("rom value wrong");

endmodule // mcf_csr

// ==== tb/mcf_host_model.sv ====
// host side model of the indexed synchronizer port
`timescale 1ns/10ps

module mcf_host_model import mcf_pkg::*; (
    // clock
    input wire logic clk_in,
    // answer from the device
    input wire logic done_in,
    input wire mcf_word_t rdata_in,
    // request to the device
    output logic valid_out,
    output mcf_cmd_s cmd_out
);
    initial begin
        valid_out = 1'b0;
        cmd_out = '0;
    end

    // every register but the serial rom value is reached only by index and value word
    task automatic access(input logic wr, input logic [7:0] idx, input mcf_word_t val,
                          output mcf_word_t rd, output logic [31:0] lat);
        @(negedge clk_in);
        valid_out = 1'b1;
        cmd_out = '{wr, idx, val};
        @(negedge clk_in);
        valid_out = 1'b0;
        // released fields get a changed pattern, never the old value
        cmd_out = ~cmd_out;
        lat = 0;
        while (done_in !== 1'b1 && lat < 4) begin
            @(posedge clk_in);
            #1;
            lat++;
        end
        lat++;
        rd = rdata_in;
    endtask
endmodule // mcf_host_model

// ==== tb/tb.sv ====
// self-checking bench of the mac control and filter registers
`timescale 1ns/10ps

module tb import mcf_pkg::*; ;
    logic CLOCK_IN, RST_IN, CMD_VALID_IN, CMD_DONE_OUT, ROM_WR_IN, ROM_LOAD_IN, TXEN_IN;
    logic PHY_TXEN_OUT, RX_VALID_IN, RX_DONE_OUT, LOOPBACK_OUT, LOOP_BUSY_OUT;
    logic FULL_DUPLEX_OUT, HEARTBEAT_EN_OUT, RX_GATE_OUT;
    mcf_cmd_s CMD_IN;
    mcf_word_t CMD_RDATA_OUT, ROM_WDATA_IN, ROM_RDATA_OUT, rd, v;
    logic [7:0] ROM_LOAD_DATA_IN;
    mcf_rx_s RX_IN;
    mcf_rx_res_s RX_RES_OUT;
    mcf_word_t sh [0:15];
    logic [31:0] lat;
    logic [47:0] da;
    int failures, num_checks, seed, n;

    mcf_csr #(.LOOP_SETTLE_CYC(4)) dut (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
        .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN), .CMD_DONE_OUT(CMD_DONE_OUT),
        .CMD_RDATA_OUT(CMD_RDATA_OUT), .ROM_WR_IN(ROM_WR_IN), .ROM_WDATA_IN(ROM_WDATA_IN),
        .ROM_LOAD_IN(ROM_LOAD_IN), .ROM_LOAD_DATA_IN(ROM_LOAD_DATA_IN),
        .ROM_RDATA_OUT(ROM_RDATA_OUT), .TXEN_IN(TXEN_IN), .PHY_TXEN_OUT(PHY_TXEN_OUT),
        .RX_VALID_IN(RX_VALID_IN), .RX_IN(RX_IN), .RX_DONE_OUT(RX_DONE_OUT),
        .RX_RES_OUT(RX_RES_OUT), .LOOPBACK_OUT(LOOPBACK_OUT), .LOOP_BUSY_OUT(LOOP_BUSY_OUT),
        .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT), .HEARTBEAT_EN_OUT(HEARTBEAT_EN_OUT),
        .RX_GATE_OUT(RX_GATE_OUT));

    mcf_host_model host (.clk_in(CLOCK_IN), .done_in(CMD_DONE_OUT),
        .rdata_in(CMD_RDATA_OUT), .valid_out(CMD_VALID_IN), .cmd_out(CMD_IN));

    initial begin
        CLOCK_IN = 1'b0;
        forever #4 CLOCK_IN = ~CLOCK_IN;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic mcf_word_t rst_val(input int i);
        case (i)
            1: return 32'h00040000;
            2: return 32'h0000ffff;
            3: return 32'h0fffffff;
            default: return 32'h00000000;
        endcase
    endfunction

    // own crc so the expectation does not lean on the design's hashing
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        logic b;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            b = a[i] ^ c[31];
            c = {c[30:0], 1'b0} ^ (b ? 32'h04c11db7 : 32'h0);
        end
        return c[31:26];
    endfunction

    function automatic logic [2:0] exp_rx(input mcf_word_t c, input logic [47:0] a,
                                          input logic dmg, input logic tx);
        logic [63:0] h;
        logic blk, ap;
        h = {sh[4], sh[5]};
        blk = c[23] & tx;
        if (c[18]) ap = 1'b1;
        else if (c[15]) ap = h[hidx(a)];
        else if (a[0]) ap = c[19] | h[hidx(a)];
        else ap = (a == {sh[2][15:0], sh[3]}) ^ c[17];
        return {!blk & (ap | c[31]) & (!dmg | c[16]), ap, blk};
    endfunction

    task automatic wr(input logic [7:0] i, input mcf_word_t val);
        host.access(1'b1, i, val, rd, lat);
        sh[i[3:0]] = (i == 8'h01) ? (val & 32'h80bf8000) : val;
        check("wr_rdata", rd, 0);
    endtask

    task automatic rdc(input logic [7:0] i);
        host.access(1'b0, i, 0, rd, lat);
        check("rd_value", rd, (i >= 1 && i <= 12) ? sh[i[3:0]] : 32'h0);
        check("rd_latency", lat, 1);
    endtask

    task automatic rx(input logic [47:0] a, input logic dmg, input logic tx);
        logic [2:0] e;
        e = exp_rx(sh[1], a, dmg, tx);
        @(negedge CLOCK_IN);
        RX_VALID_IN = 1'b1;
        RX_IN = '{a, dmg};
        TXEN_IN = tx;
        @(negedge CLOCK_IN);
        RX_VALID_IN = 1'b0;
        RX_IN = ~RX_IN;
        check("rx_done", RX_DONE_OUT, 1);
        check("rx_res", RX_RES_OUT, e);
    endtask

    initial begin
        #200us;
        failures++;
        give_verdict();
    end

    initial begin
        seed = 30;
        RST_IN = 1'b1;
        ROM_WR_IN = 1'b0;
        ROM_WDATA_IN = '0;
        ROM_LOAD_IN = 1'b0;
        ROM_LOAD_DATA_IN = '0;
        TXEN_IN = 1'b0;
        RX_VALID_IN = 1'b0;
        RX_IN = '0;
        repeat (6) @(posedge CLOCK_IN);
        @(negedge CLOCK_IN);
        RST_IN = 1'b0;
        for (int i = 0; i < 16; i++) sh[i] = rst_val(i);
        for (int i = 0; i < 14; i++) rdc(i);
        $display("test reset values done");
        // random words everywhere, unmapped indices included; loopback kept off,
        // own-frame blocking only in half duplex
        for (int i = 0; i < 14; i++) begin
            v = $random(seed);
            wr(i, (i == 1) ? (v & ~(v[20] ? 32'h00a00000 : 32'h00200000)) : v);
            rdc(i);
        end
        $display("test register access done");
        for (int k = 0; k < 300; k++) begin
            v = $random(seed);
            if (v[2:0] == 3'h0) wr(8'h01, v & ~(v[20] ? 32'h00a00000 : 32'h00200000));
            if (v[5:3] == 3'h1) wr(8'h04 + v[6], $random(seed));
            da = {$random(seed), $random(seed)};
            if (v[9:8] == 2'h0) da = {sh[2][15:0], sh[3]};
            if (k % 20 == 0) da = 48'hffffffffffff;
            rx(da, v[10] & v[11], v[12]);
        end
        $display("test address filter done");
        wr(8'h01, 32'h00100000);
        check("full_duplex", {FULL_DUPLEX_OUT, HEARTBEAT_EN_OUT}, 2'b10);
        // transmitter idle across every turnaround change
        TXEN_IN = 1'b0;
        wr(8'h01, 32'h00300000);
        check("loop_pending", {LOOP_BUSY_OUT, LOOPBACK_OUT}, 2'b10);
        n = 0;
        while (LOOPBACK_OUT !== 1'b1 && n < 20) begin
            @(posedge CLOCK_IN);
            #1;
            n++;
        end
        check("loop_delay", (n >= 2 && n <= 7), 1);
        @(negedge CLOCK_IN);
        TXEN_IN = 1'b1;
        #1;
        check("loop_tx", {PHY_TXEN_OUT, LOOP_BUSY_OUT}, 2'b00);
        @(negedge CLOCK_IN);
        TXEN_IN = 1'b0;
        wr(8'h01, 32'h00100000);
        repeat (8) @(posedge CLOCK_IN);
        @(negedge CLOCK_IN);
        TXEN_IN = 1'b1;
        #1;
        check("normal_tx", {PHY_TXEN_OUT, LOOPBACK_OUT}, 2'b10);
        wr(8'h01, 32'h00800000);
        check("rx_gate_tx", RX_GATE_OUT, 0);
        check("half_duplex", {FULL_DUPLEX_OUT, HEARTBEAT_EN_OUT}, 2'b01);
        TXEN_IN = 1'b0;
        #1;
        check("rx_gate_idle", RX_GATE_OUT, 1);
        $display("test modes done");
        for (int k = 0; k < 6; k++) begin
            @(negedge CLOCK_IN);
            v = $random(seed);
            ROM_WR_IN = 1'b1;
            ROM_WDATA_IN = v;
            ROM_LOAD_IN = k[0];
            ROM_LOAD_DATA_IN = ~v[7:0];
            @(negedge CLOCK_IN);
            ROM_WR_IN = 1'b0;
            ROM_LOAD_IN = 1'b0;
            ROM_WDATA_IN = ~v;
            check("rom_value", ROM_RDATA_OUT, {24'h0, k[0] ? ~v[7:0] : v[7:0]});
        end
        $display("test rom value done");
        give_verdict();
    end
endmodule // tb
